// [rtl/sspmgt_map.vh]
// constants for the strobed serial management port
// assumes includer uses these for bit counts, addresses and defaults
// Functional notes
// - the link uses three wires, serial input, acknowledge output and strobe.
// - the strobe is the one clock for both the inbound and outbound bit streams.
// - every configuration register can be written by the host over the link.
// - a transfer is start pulse, address, read/write command, then data, in that order.
// - start is input high at a strobe rise then low at the next strobe fall.
// - after start the address bits are shifted in, each taken while the strobe is high.
// - write data arrives on the serial input; read data leaves on the acknowledge output.
// - an abort is honoured at any point and leaves no partial write behind.
// - abort is input low at a strobe rise then high at the next strobe fall.
// - the link is synchronous serial, one bit per strobe cycle per line.
// - every register is eight bits wide so each data phase is one byte.
// - every register is reachable only through this link; no other path reaches the file.
// - the link check register at h36 reads back the fixed byte hDA.
`ifndef SSPMGT_MAP_VH
`define SSPMGT_MAP_VH
`define SSPMGT_ADDR_W 8
`define SSPMGT_DATA_W 8
`define SSPMGT_CNT_W 4
`define SSPMGT_CMD_READ 1'h1
`define SSPMGT_CHECK_ADDR 8'h36
`define SSPMGT_CHECK_VAL 8'hDA
`define SSPMGT_REG_DEPTH 256
`define SSPMGT_REG_RST 8'h00
`endif

// [rtl/sspmgt_sync.v]
// two flop synchroniser for one asynchronous level
// assumes clock is the system clock; input comes from a pin
`default_nettype none
module sspmgt_sync (
  input wire clock,
  input wire sys_rst,
  input wire asyncIn,
  output reg syncOut
);
  reg meta_reg;
  always @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= 1'h0;
      syncOut <= 1'h0;
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end
endmodule // sspmgt_sync
`default_nettype wire

// [rtl/sspmgt_port.v]
// strobed serial management port with its eight bit register file
// assumes strobe and serial input are pins, far slower than clock
`include "sspmgt_map.vh"
`default_nettype none
module sspmgt_port #(
  parameter ADDR_W = `SSPMGT_ADDR_W,
  parameter DATA_W = `SSPMGT_DATA_W
) (
  input wire clock,
  input wire sys_rst,
  input wire host_serial_in,
  input wire hostStrobe,
  output reg deviceAck,
  output reg writePulse,
  output reg [ADDR_W-1:0] writeAddr,
  output reg [DATA_W-1:0] writeData
);
  localparam CNT_W = `SSPMGT_CNT_W;
  localparam REG_DEPTH = `SSPMGT_REG_DEPTH;
  localparam integer ADDR_LAST = ADDR_W - 1;
  localparam integer DATA_LAST = DATA_W - 1;
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'h0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'h0}}, 1'h1};

  // one-hot sequencer states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_CMD = 5'h04;
  localparam [4:0] ST_WDAT = 5'h08;
  localparam [4:0] ST_RDAT = 5'h10;

  // synchronised link wires and their edges
  wire strobeSync;
  wire dataSync;
  wire strobeRise;
  wire strobeFall;
  wire startSeen;
  wire abortSeen;
  // bit counter end points and decoded command
  wire [31:0] countWide;
  wire addrLast;
  wire dataLast;
  wire readCmd;
  wire [DATA_W-1:0] readValue;
  wire [DATA_W-1:0] writeByte;

  // sequencer registers and their next values
  reg strobeLast_reg;
  reg riseBit_reg;
  reg riseBit_next;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] count_next;
  reg [ADDR_W-1:0] addr_reg;
  reg [ADDR_W-1:0] addr_next;
  reg [DATA_W-1:0] shift_reg;
  reg [DATA_W-1:0] shift_next;
  reg deviceAck_next;
  reg writePulse_next;
  reg [ADDR_W-1:0] writeAddr_next;
  reg [DATA_W-1:0] writeData_next;
  reg [DATA_W-1:0] regFile [0:REG_DEPTH-1];
  integer i;

  // three link wires: strobe and serial input in, ack out
  sspmgt_sync uStrobe (
    .clock(clock),
    .sys_rst(sys_rst),
    .asyncIn(hostStrobe),
    .syncOut(strobeSync)
  );
  sspmgt_sync uData (
    .clock(clock),
    .sys_rst(sys_rst),
    .asyncIn(host_serial_in),
    .syncOut(dataSync)
  );

  // strobe idles low, so the cleared last sample gives no false rise after reset
  assign strobeRise = strobeSync & ~strobeLast_reg;
  assign strobeFall = ~strobeSync & strobeLast_reg;
  // rise/fall pair: a data change while strobe high is a framing mark
  assign startSeen = strobeFall & riseBit_reg & ~dataSync;
  assign abortSeen = strobeFall & ~riseBit_reg & dataSync;

  // widen the counter so the end points compare at one width
  assign countWide = {{(32-CNT_W){1'h0}}, count_reg};
  assign addrLast = (countWide == ADDR_LAST);
  assign dataLast = (countWide == DATA_LAST);
  assign readCmd = (riseBit_reg == `SSPMGT_CMD_READ);
  assign writeByte = {shift_reg[DATA_W-2:0], riseBit_reg};

  // link check byte is fixed, not stored
  // a write to that address still lands in the file, reads never see it
  assign readValue = (addr_reg == `SSPMGT_CHECK_ADDR) ? `SSPMGT_CHECK_VAL
    : regFile[addr_reg];

  // bit level sequencing, acted on at each synchronised strobe fall
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    addr_next = addr_reg;
    shift_next = shift_reg;
    riseBit_next = riseBit_reg;
    deviceAck_next = deviceAck;
    writePulse_next = 1'h0;
    writeAddr_next = writeAddr;
    writeData_next = writeData;
    if (strobeRise) begin
      riseBit_next = dataSync; // bit taken while strobe high
    end
    if (abortSeen) begin
      // nothing written until the last data bit, so abort leaves no trace
      state_next = ST_IDLE;
      deviceAck_next = 1'h0;
    end else if (startSeen) begin
      // a start inside a frame restarts it
      state_next = ST_ADDR;
      count_next = CNT_ZERO;
      deviceAck_next = 1'h0;
    end else if (strobeFall) begin
      // one bit per strobe cycle; framing marks take priority above
      case (state_reg)
        ST_IDLE: begin
          deviceAck_next = 1'h0;
        end
        ST_ADDR: begin
          addr_next = {addr_reg[ADDR_W-2:0], riseBit_reg}; // msb first
          if (addrLast) begin
            state_next = ST_CMD;
            count_next = CNT_ZERO;
          end else begin
            count_next = count_reg + CNT_ONE;
          end
        end
        ST_CMD: begin
          count_next = CNT_ZERO;
          if (readCmd) begin
            // msb goes out now, the rest on the following falls
            state_next = ST_RDAT;
            shift_next = {readValue[DATA_W-2:0], 1'h0};
            deviceAck_next = readValue[DATA_W-1];
          end else begin
            state_next = ST_WDAT;
          end
        end
        ST_WDAT: begin
          shift_next = writeByte;
          if (dataLast) begin
            // the only place a write is committed
            state_next = ST_IDLE;
            writePulse_next = 1'h1;
            writeAddr_next = addr_reg;
            writeData_next = writeByte;
          end else begin
            count_next = count_reg + CNT_ONE;
          end
        end
        ST_RDAT: begin
          if (dataLast) begin
            state_next = ST_IDLE;
            deviceAck_next = 1'h0;
          end else begin
            deviceAck_next = shift_reg[DATA_W-1];
            shift_next = {shift_reg[DATA_W-2:0], 1'h0};
            count_next = count_reg + CNT_ONE;
          end
        end
        default: begin
          state_next = ST_IDLE;
          deviceAck_next = 1'h0;
        end
      endcase
    end
  end

  // edge detector and sequencer state
  always @(posedge clock) begin
    if (sys_rst) begin
      strobeLast_reg <= 1'h0;
      riseBit_reg <= 1'h0;
      state_reg <= ST_IDLE;
      count_reg <= CNT_ZERO;
      addr_reg <= {ADDR_W{1'h0}};
      shift_reg <= {DATA_W{1'h0}};
    end else begin
      strobeLast_reg <= strobeSync;
      riseBit_reg <= riseBit_next;
      state_reg <= state_next;
      count_reg <= count_next;
      addr_reg <= addr_next;
      shift_reg <= shift_next;
    end
  end

  // outputs straight from flops, cleared in reset
  always @(posedge clock) begin
    if (sys_rst) begin
      deviceAck <= 1'h0;
      writePulse <= 1'h0;
      writeAddr <= {ADDR_W{1'h0}};
      writeData <= {DATA_W{1'h0}};
    end else begin
      deviceAck <= deviceAck_next;
      writePulse <= writePulse_next;
      writeAddr <= writeAddr_next;
      writeData <= writeData_next;
    end
  end

  // register file: all link-only here, other paths would add ports
  // reset clears every entry in one edge; no per-address defaults are kept
  always @(posedge clock) begin
    if (sys_rst) begin
      for (i = 0; i < REG_DEPTH; i = i + 1) begin
        regFile[i] <= `SSPMGT_REG_RST;
      end
    end else if (writePulse) begin
      regFile[writeAddr] <= writeData;
    end
  end
endmodule // sspmgt_port
`default_nettype wire

// [dv/sspmgt_port_props.sv]
// pin-level assertions for the management port
// assumes binding onto sspmgt_port
`default_nettype none
module sspmgt_port_props #(parameter ADDR_W = 8, parameter DATA_W = 8) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic host_serial_in,
  input wire logic hostStrobe,
  input wire logic deviceAck,
  input wire logic writePulse,
  input wire logic [ADDR_W-1:0] writeAddr,
  input wire logic [DATA_W-1:0] writeData
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rst; $fell(sys_rst) |-> !deviceAck && !writePulse && writeAddr == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_gap; writePulse |=> !writePulse [*8]; endproperty
  a_gap: assert property (p_gap) else $error("writes too close");
  property p_hold; $changed(writeAddr) || $changed(writeData) |-> writePulse; endproperty
  a_hold: assert property (p_hold) else $error("write outputs moved alone");
  property p_ack; $changed(deviceAck) |-> !$past(hostStrobe, 3) && $past(hostStrobe, 4); endproperty
  a_ack: assert property (p_ack) else $error("ack moved away from a fall");
  property p_wr; writePulse |-> !hostStrobe && !$past(hostStrobe, 3) && $past(hostStrobe, 4); endproperty
  a_wr: assert property (p_wr) else $error("write away from a fall");
  property p_noack; writePulse |-> !deviceAck; endproperty
  a_noack: assert property (p_noack) else $error("ack high at a write");
  property p_rise; $rose(hostStrobe) |=> $stable(deviceAck) [*2]; endproperty
  a_rise: assert property (p_rise) else $error("ack moved after rise");
  property p_high; hostStrobe [*4] |-> !writePulse && $stable(deviceAck); endproperty
  a_high: assert property (p_high) else $error("activity with strobe high");
endmodule // sspmgt_port_props
bind sspmgt_port sspmgt_port_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clock, .sys_rst,
  .host_serial_in, .hostStrobe, .deviceAck, .writePulse, .writeAddr, .writeData);
`default_nettype wire

// [dv/sspmgt_host.sv]
// host end of the link: strobe, serial bit, ack capture
// assumes bench clock of 25 ns, so one strobe cycle is 8 clocks
`default_nettype none
module sspmgt_host (
  input wire logic clock,
  input wire logic deviceAck,
  output logic hostStrobe,
  output logic serialOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rdByte;
  initial hostStrobe = 1'h0; // strobe stands still between frames
  initial serialOut = 1'h0;
  // r == f is a plain bit; 1/0 is start, 0/1 is abort
  task automatic cyc(input logic r, input logic f);
    serialOut <= r;
    @(posedge clock);
    hostStrobe <= 1'h1;
    repeat (2) @(posedge clock);
    serialOut <= f;
    repeat (2) @(posedge clock);
    rdByte <= {rdByte[6:0], deviceAck};
    hostStrobe <= 1'h0;
    repeat (3) @(posedge clock);
  endtask
  // fewer than 8 data bits ends the frame with an abort
  task automatic xfer(input logic [7:0] a, input logic rd, input logic [7:0] d, input int n);
    cyc(1'h1, 1'h0);
    for (int i = 7; i >= 0; i--) cyc(a[i], a[i]);
    cyc(rd, rd);
    for (int i = 7; i >= 8 - n; i--) cyc(d[i], d[i]);
    if (n < 8) cyc(1'h0, 1'h1);
  endtask
endmodule // sspmgt_host
`default_nettype wire

// [dv/test_strobed_serial_register_port.sv]
// self-checking bench for the management port
// assumes the host model drives the link pins
`include "sspmgt_map.vh"
`default_nettype none
module test_strobed_serial_register_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic hostStrobe, serialIn, deviceAck, writePulse;
  logic [7:0] writeAddr, writeData;
  int mismatches = 0;
  int n_compared = 0;
  int nWrites = 0;
  always #12.5 clock = ~clock;
  always @(posedge clock) if (writePulse === 1'h1) nWrites <= nWrites + 1;
  sspmgt_host host (.clock, .deviceAck, .hostStrobe, .serialOut(serialIn));
  sspmgt_port uut (.clock, .sys_rst, .host_serial_in(serialIn), .hostStrobe, .deviceAck,
    .writePulse, .writeAddr, .writeData);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic write_then_read(input logic [7:0] a, input logic [7:0] d);
    int b;
    b = nWrites;
    host.xfer(a, 1'h0, d, 8);
    repeat (8) @(posedge clock);
    chk("wr count", 8'(b + 1), 8'(nWrites));
    chk("wr addr", a, writeAddr);
    chk("wr data", d, writeData);
    host.xfer(a, 1'h1, 8'h00, 8);
    chk("rd data", (a == `SSPMGT_CHECK_ADDR) ? `SSPMGT_CHECK_VAL : d, host.rdByte);
    repeat (2) @(posedge clock);
    chk("ack idle", 8'h00, {7'h00, deviceAck});
  endtask
  task automatic abort_then_read(input logic [7:0] a, input logic [7:0] old, input int n);
    int b;
    b = nWrites;
    host.xfer(a, 1'h0, ~old, n);
    repeat (8) @(posedge clock);
    chk("abort count", 8'(b), 8'(nWrites));
    host.xfer(a, 1'h1, 8'h00, 8);
    chk("abort rd", old, host.rdByte);
  endtask
  // mid-run reset clears the held write outputs and the file entry at address a
  task automatic reset_then_read(input logic [7:0] a);
    sys_rst <= 1'h1;
    repeat (8) @(posedge clock);
    chk("rst addr", 8'h00, writeAddr);
    chk("rst data", 8'h00, writeData);
    sys_rst <= 1'h0;
    host.xfer(a, 1'h1, 8'h00, 8);
    chk("rst rd", `SSPMGT_REG_RST, host.rdByte);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'h0;
    abort_then_read(8'h55, 8'h00, 0);
    write_then_read(8'h00, 8'hA5);
    write_then_read(8'hFF, 8'h5A);
    write_then_read(8'h36, 8'h3C);
    abort_then_read(8'hFF, 8'h5A, 7);
    abort_then_read(8'h00, 8'hA5, 3);
    reset_then_read(8'h00);
    tally_and_finish;
  end
endmodule // test_strobed_serial_register_port
`default_nettype wire
